// *** src/rng_pkg.sv ***
// Purpose: Constants for the reset, non-maskable trap and power-down gate
// Assumes: CPU clock of 25 MHz, period 40 ns
// Notes:   Filter times are given in ns and turned into cycle counts here

package rng_pkg;

	localparam int CLK_PERIOD_NS   = 40;
	localparam int SPIKE_MAX_NS    = 10;
	localparam int ACCEPT_MIN_NS   = 100;
	// Longest ignored pulse rounds down, never below one cycle
	localparam int SPIKE_CYC       = (SPIKE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (SPIKE_MAX_NS / CLK_PERIOD_NS);
	// Accepted pulse rounds up
	localparam int ACCEPT_CYC      = (ACCEPT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W          = 4;
	localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(ACCEPT_CYC);
	localparam logic [FILT_W-1:0] FILT_RST   = 4'h0;
	localparam logic [1:0]        STRAP_RST  = 2'h0;

	typedef enum logic [1:0] {
		RNG_RUN,
		RNG_RESET,
		RNG_PDOWN
	} rng_mode_t;

endpackage : rng_pkg

// *** src/rng_gate.sv ***
// Purpose: Qualify external reset, raise non-maskable trap, gate power-down
// Assumes: Oscillator running; all pins asynchronous to clk
// Notes:   Strap and debug levels are captured on reset release

`timescale 1ns/1ps

module rng_gate
	import rng_pkg::*;
(
	input  wire logic       clk,                     // CPU clock
	input  wire logic       arst_n,                  // Power-on reset
	input  wire logic       external_reset_in_n,     // Reset pin
	input  wire logic       nmi_in_n,                // Trap pin
	input  wire logic       debug_reset_in,          // Debug reset pin
	input  wire logic       config_strap_bit_a,      // Strap pin a
	input  wire logic       config_strap_bit_b,      // Strap pin b
	input  wire logic       power_down_instruction,  // One-cycle pulse from CPU
	output logic            reset_out,               // Qualified device reset
	output logic            nmi_trap_req,            // One-cycle trap request
	output logic            power_down,              // Power-down mode level
	output logic [1:0]      startup_config,          // Captured straps
	output logic            hw_config_en,            // Debug configuration on
	output logic            debug_active             // Debug system on
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	// The low counter saturates at its limit, so the limit must fit four bits
	initial begin
		if (ACCEPT_CYC > 15 || ACCEPT_CYC < 1) begin
			$error("Filter count does not fit");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Every pin has its own two-stage chain; nothing reads a first stage
	typedef struct packed {
		logic [1:0]        rst_sync;
		logic [1:0]        nmi_sync;
		logic [1:0]        dbg_sync;
		logic [1:0]        sa_sync;
		logic [1:0]        sb_sync;
		logic              nmi_last;
		logic [FILT_W-1:0] low_cnt;
		rng_mode_t         mode;
		logic              trap;
		logic [1:0]        straps;
		logic              hw_cfg;
		logic              dbg_act;
	} rng_state_t;

	rng_state_t st;
	rng_state_t next_st;

	// ----------------------------------------------------------------
	// Filter decode
	// ----------------------------------------------------------------
	// Shared by run and power-down so both leave on the same low length
	function automatic logic accept_low(logic synced_n, logic [FILT_W-1:0] cnt);
		return !synced_n && cnt == FILT_LIMIT - 4'h1;
	endfunction : accept_low

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st          = st;
		next_st.rst_sync = {st.rst_sync[0], external_reset_in_n};
		next_st.nmi_sync = {st.nmi_sync[0], nmi_in_n};
		next_st.dbg_sync = {st.dbg_sync[0], debug_reset_in};
		next_st.sa_sync  = {st.sa_sync[0], config_strap_bit_a};
		next_st.sb_sync  = {st.sb_sync[0], config_strap_bit_b};
		next_st.nmi_last = st.nmi_sync[1];
		next_st.trap     = st.nmi_last & ~st.nmi_sync[1];
		// Low count saturates; short lows restart it when the pin goes high
		if (st.rst_sync[1]) begin
			next_st.low_cnt = FILT_RST;
		end else if (st.low_cnt != FILT_LIMIT) begin
			next_st.low_cnt = st.low_cnt + 4'h1;
		end
		case (st.mode)
			RNG_RUN: begin
				// Reset beats a power-down request in the same cycle
				if (accept_low(st.rst_sync[1], st.low_cnt)) begin
					next_st.mode = RNG_RESET;
				end else if (power_down_instruction && !st.nmi_sync[1]) begin
					next_st.mode = RNG_PDOWN;
				end
			end
			RNG_RESET: begin
				if (st.rst_sync[1]) begin
					next_st.mode    = RNG_RUN;
					next_st.straps  = {st.sb_sync[1], st.sa_sync[1]};
					next_st.hw_cfg  = st.dbg_sync[1];
					next_st.dbg_act = st.dbg_sync[1];
				end
			end
			RNG_PDOWN: begin
				// Only a reset leaves power-down
				if (accept_low(st.rst_sync[1], st.low_cnt)) begin
					next_st.mode = RNG_RESET;
				end
			end
			default: next_st.mode = RNG_RESET;
		endcase
		// Debug logic is cleared by a later low on the debug pin
		if (st.mode != RNG_RESET && !st.dbg_sync[1]) begin
			next_st.dbg_act = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Trap chain resets high so release with the trap pin high never looks like a falling edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{rst_sync: 2'h0, nmi_sync: 2'h3, dbg_sync: 2'h0, sa_sync: 2'h0,
			        sb_sync: 2'h0, nmi_last: 1'b1, low_cnt: FILT_RST, mode: RNG_RESET,
			        trap: 1'b0, straps: STRAP_RST, hw_cfg: 1'b0, dbg_act: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reset_out      = (st.mode == RNG_RESET);
	assign nmi_trap_req   = st.trap;
	assign power_down     = (st.mode == RNG_PDOWN);
	assign startup_config = st.straps;
	assign hw_config_en   = st.hw_cfg;
	assign debug_active   = st.dbg_act;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_reset_entry: assert property (@(posedge clk) disable iff (!arst_n)
		(!st.rst_sync[1])[*3] |-> ##1 reset_out) else $error("Held low reset not taken");
	a_spike_drop: assert property (@(posedge clk) disable iff (!arst_n)
		(!reset_out && st.rst_sync[1]) ##1 !st.rst_sync[1] ##1 st.rst_sync[1] |=> !reset_out)
		else $error("Single cycle low caused reset");
	a_trap_once: assert property (@(posedge clk) disable iff (!arst_n)
		nmi_trap_req |=> !nmi_trap_req) else $error("Trap longer than a cycle");
	a_trap_edge: assert property (@(posedge clk) disable iff (!arst_n)
		($fell(st.nmi_sync[1])) |=> nmi_trap_req) else $error("Trap edge missed");
	a_pd_enter: assert property (@(posedge clk) disable iff (!arst_n)
		(st.mode == RNG_RUN && power_down_instruction && !st.nmi_sync[1] && st.rst_sync[1])
		|=> power_down) else $error("Power-down not entered");
	a_pd_ignore: assert property (@(posedge clk) disable iff (!arst_n)
		(st.mode == RNG_RUN && power_down_instruction && st.nmi_sync[1]) |=> !power_down)
		else $error("Power-down taken with trap pin high");
	a_strap_take: assert property (@(posedge clk) disable iff (!arst_n)
		(reset_out && st.rst_sync[1]) |=> startup_config == $past({st.sb_sync[1], st.sa_sync[1]}))
		else $error("Straps not captured");
	a_debug_take: assert property (@(posedge clk) disable iff (!arst_n)
		(reset_out && st.rst_sync[1]) |=> hw_config_en == $past(st.dbg_sync[1]))
		else $error("Debug level not captured");
	a_reset_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(reset_out && !st.rst_sync[1]) |=> reset_out)
		else $error("Reset left while pin low");
	a_reset_exit: assert property (@(posedge clk) disable iff (!arst_n)
		(reset_out && st.rst_sync[1]) |=> !reset_out)
		else $error("Reset kept after pin high");
	a_reset_cause: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(reset_out) |-> $past(!st.rst_sync[1]))
		else $error("Reset entered without low pin");
	a_pd_reset: assert property (@(posedge clk) disable iff (!arst_n)
		(power_down && accept_low(st.rst_sync[1], st.low_cnt)) |=> reset_out)
		else $error("Reset not taken from power-down");
	a_pd_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(power_down && st.rst_sync[1]) |=> power_down)
		else $error("Power-down left without reset");
	a_pd_cause: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(power_down) |-> $past(power_down_instruction && !st.nmi_sync[1]))
		else $error("Power-down entered without request");
	a_filter_sat: assert property (@(posedge clk) disable iff (!arst_n)
		st.low_cnt <= FILT_LIMIT)
		else $error("Low counter beyond limit");
	a_filter_clear: assert property (@(posedge clk) disable iff (!arst_n)
		st.rst_sync[1] |=> st.low_cnt == FILT_RST)
		else $error("Low counter not restarted");
	a_trap_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		!$fell(st.nmi_sync[1]) |=> !nmi_trap_req)
		else $error("Trap without falling edge");
	a_strap_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(reset_out && st.rst_sync[1]) |=> $stable(startup_config))
		else $error("Straps changed outside release");
	a_hwcfg_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(reset_out && st.rst_sync[1]) |=> $stable(hw_config_en))
		else $error("Configuration enable changed outside release");
	a_dbg_clear: assert property (@(posedge clk) disable iff (!arst_n)
		(!reset_out && !st.dbg_sync[1]) |=> !debug_active)
		else $error("Debug not cleared by low pin");
	a_dbg_no_set: assert property (@(posedge clk) disable iff (!arst_n)
		(!reset_out && !debug_active) |=> !debug_active)
		else $error("Debug set outside release");

endmodule : rng_gate

// *** dv/rng_partner.sv ***
// Purpose: Model of reset circuitry and trap source
// Assumes: Pins change on falling clk
// Notes:   Straps invert and debug drops after hold
`timescale 1ns/1ps
module rng_partner (
	input  wire logic       clk,   // CPU clock
	output logic            rst_n, // Reset pin
	output logic            nmi_n, // Trap pin
	output logic            dbg,   // Debug reset pin
	output logic [1:0]      strap  // Strap pins
);
	initial begin
		rst_n = 1'h1;
		nmi_n = 1'h1;
		dbg   = 1'h0;
		strap = 2'h3;
	end
	task hold_reset(int n, logic d, logic [1:0] s);
		@(negedge clk);
		dbg   = d;
		strap = s;
		rst_n = 1'h0;
		repeat (n) @(negedge clk);
		rst_n = 1'h1;
		fork
			begin
				repeat (5) @(negedge clk);
				strap = ~s;
				dbg   = 1'h0;
			end
		join_none
	endtask : hold_reset
	task set_nmi(logic v);
		@(negedge clk);
		nmi_n = v;
	endtask : set_nmi
endmodule : rng_partner

// *** dv/rng_gate_tb.sv ***
// Purpose: Self-checking bench for rng_gate
// Assumes: Inputs change on falling clk
// Notes:   Filter delays judged by bounded waits
`timescale 1ns/1ps
module rng_gate_tb;
	logic       clk = 1'h0, arst_n = 1'h0, pdi = 1'h0;
	logic       rst_n, nmi_n, dbg, rso, trap, pd, hwc, dba;
	logic [1:0] strap, cfg;
	int         fails = 0, num_checks = 0;
	always #20 clk = ~clk;
	rng_partner p (.clk(clk), .rst_n(rst_n), .nmi_n(nmi_n), .dbg(dbg), .strap(strap));
	rng_gate dut (.clk(clk), .arst_n(arst_n), .external_reset_in_n(rst_n), .nmi_in_n(nmi_n),
		.debug_reset_in(dbg), .config_strap_bit_a(strap[0]), .config_strap_bit_b(strap[1]),
		.power_down_instruction(pdi), .reset_out(rso), .nmi_trap_req(trap), .power_down(pd),
		.startup_config(cfg), .hw_config_en(hwc), .debug_active(dba));
	task chk(string n, logic [1:0] e, logic [1:0] s);
		num_checks++;
		if (s !== e) begin
			$display("unexpected %s exp %h got %h", n, e, s);
			fails++;
		end
	endtask : chk
	task test_done;
		$display("fails %0d num_checks %0d", fails, num_checks);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task t_reset(logic d, logic [1:0] s);
		p.hold_reset(8, d, s);
		chk("reset_out", 2'h1, rso);
		for (int i = 0; i < 8 && rso !== 1'h0; i++) @(negedge clk);
		chk("reset_out", 2'h0, rso);
		chk("startup_config", s, cfg);
		chk("debug_active", d, dba);
		chk("power_down", 2'h0, pd);
		repeat (8) @(negedge clk);
		chk("debug_active", 2'h0, dba);
		chk("hw_config_en", d, hwc);
	endtask : t_reset
	task t_spike;
		logic seen;
		seen = 1'h0;
		p.hold_reset(1, 1'h0, 2'h0);
		repeat (10) @(negedge clk) seen |= rso;
		chk("spike", 2'h0, seen);
	endtask : t_spike
	task t_nmi;
		int n;
		n = 0;
		p.set_nmi(1'h0);
		repeat (8) @(negedge clk) n += trap;
		chk("trap count", 2'h1, n[1:0]);
		p.set_nmi(1'h1);
		repeat (8) @(negedge clk) n += trap;
		chk("trap count", 2'h1, n[1:0]);
	endtask : t_nmi
	task pulse_pd;
		@(negedge clk);
		pdi = 1'h1;
		@(negedge clk);
		pdi = 1'h0;
		repeat (2) @(negedge clk);
	endtask : pulse_pd
	task t_pdown;
		pulse_pd;
		chk("power_down", 2'h0, pd);
		p.set_nmi(1'h0);
		repeat (3) @(negedge clk);
		pulse_pd;
		chk("power_down", 2'h1, pd);
		p.set_nmi(1'h1);
	endtask : t_pdown
	initial begin
		repeat (16) @(negedge clk);
		arst_n = 1'h1;
		t_reset(1'h1, 2'h2);
		t_spike;
		t_nmi;
		t_pdown;
		t_reset(1'h0, 2'h1);
		test_done;
	end
	initial begin
		#(40 * 2000);
		fails++;
		test_done;
	end
endmodule : rng_gate_tb
